//--- src/eeprom_rd_regs.svh
/*
  Constants of the two-wire EEPROM read and security region logic.
  Assumes it is included by bare name after the package.
*/
`ifndef EEPROM_RD_REGS_SVH
`define EEPROM_RD_REGS_SVH

// ==========================================================
// Device address byte
`define DEV_TYPE_ARRAY 4'ha
`define DEV_TYPE_SEC 4'hb
`define DEV_DIR_READ 1'h1

// ==========================================================
// Word address byte
`define SEC_SEL_CODE 2'h2
`define LOCK_CMD_CODE 4'h6

// ==========================================================
// Security region layout
`define SEC_IDX_W 5
`define SEC_USER_BIT 4
`define BYTE_BITS 4'h8

// ==========================================================
// Filler sent when no read data is waiting
`define IDLE_BYTE 8'hff

`endif

//--- src/eeprom_rd_pkg.sv
/*
  Types of the two-wire EEPROM read logic.
  Assumes nothing of its surroundings.
*/
package eeprom_rd_pkg;

  // Bus phase of the client
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK,
    ST_TX_LOAD
  } phase_t;

  // Which received byte is being taken in
  typedef enum logic [1:0] {
    K_DEV,
    K_WA,
    K_WD
  } kind_t;

endpackage

//--- src/eeprom_rd.sv
/*
  Two-wire EEPROM client: reads with the shared address pointer,
  security region access and the lock command.
  Assumes a memory beside it that answers read requests in order,
  takes write strobes, and keeps the lock bit across power loss.
*/
// Function
// - A read is a write-style transfer with the direction bit set to one.
// - One pointer serves array and security region; dummy write sets it.
// - Pointer holds last accessed location plus one between transfers.
// - Read increment wraps from last byte of last page to first byte.
// - Start plus matching read address: acknowledge, send byte at pointer.
// - Host not acknowledging a data byte ends any read.
// - Repeated start with read direction returns byte at loaded address.
// - Sequential reads begin as current address or random reads.
// - Each acknowledged byte advances the pointer and sends the next.
// - Sequential read past the top address continues from address zero.
// - Security region is 32 bytes; lower 16 serial, read-only.
// - Upper half is two 8-byte pages taking byte and page writes.
// - Lock makes the user half reject all further programming.
// - Security access uses type 1011b and word address top bits 10b.
// - Security reads wrap after byte 31 back to byte 0.
// - Lock is word address 0110b; acknowledged only while unlocked.
// - Stop commits lock; after the timed cycle the region is read-only.
`include "eeprom_rd_regs.svh"

module eeprom_rd
  import eeprom_rd_pkg::*;
#(
  parameter int ADDR_W = 10,
  parameter logic [2:0] HW_ADDR = 3'h0,
  parameter int DATA_W = 8,
  parameter int DEPTH = 2,
  parameter int LOCK_CYCLES = 1024
)(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Two-wire bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // Read requests to the memory
  output logic o_req_valid,
  input wire logic i_req_ready,
  output logic [ADDR_W-1:0] o_req_addr,
  output logic o_req_sec,
  // Read data from the memory
  input wire logic i_rd_valid,
  input wire logic [DATA_W-1:0] i_rd_data,
  output logic o_rd_ready,
  // Write strobes to the memory
  output logic o_wr_valid,
  output logic [ADDR_W-1:0] o_wr_addr,
  output logic o_wr_sec,
  output logic [7:0] o_wr_data,
  // Lock state
  input wire logic i_locked_nv,
  output logic o_lock_commit,
  output logic o_locked,
  output logic o_busy
);

  localparam int HB = ADDR_W - 8;
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic scl_q;
    logic sda_q;
    phase_t ph;
    kind_t kind;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] dev;
    logic sec;
    logic [ADDR_W-1:0] ptr;
    logic sda_o;
    logic sda_oe;
    logic req_valid;
    logic [ADDR_W-1:0] req_addr;
    logic req_sec;
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] count;
    logic rd_ready;
    logic wr_valid;
    logic [ADDR_W-1:0] wr_addr;
    logic wr_sec;
    logic [7:0] wr_data;
    logic lock_op;
    logic lock_pend;
    logic busy;
    logic [31:0] busy_cnt;
    logic lock_commit;
    logic locked;
  } core_t;

  // Filters start at the idle bus level, so releasing reset makes no edge
  localparam core_t RST = '{scl_sync: 3'h7, sda_sync: 3'h7, scl_q: 1'b1,
    sda_q: 1'b1, ph: ST_IDLE, kind: K_DEV, default: '0};

  core_t st_ff;
  core_t nxt_st;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic ack;
  logic load_tx;
  logic pop;
  logic push;

  // Next pointer; the security region wraps inside its 32 bytes
  function automatic logic [ADDR_W-1:0] inc_ptr(
    input logic [ADDR_W-1:0] p,
    input logic s
  );
    logic [ADDR_W-1:0] r;
    r = p + 1'b1;
    if (s)
    begin
      r = {p[ADDR_W-1:`SEC_IDX_W],
           `SEC_IDX_W'(p[`SEC_IDX_W-1:0] + 1'b1)};
    end
    return r;
  endfunction

  // Hardware address bits sit above the array's high address bits
  function automatic logic dev_match(input logic [7:0] d);
    return (d[7:4] == `DEV_TYPE_ARRAY || d[7:4] == `DEV_TYPE_SEC) &&
           (d[3:HB+1] == HW_ADDR[2:HB]);
  endfunction

  always_comb
  begin
    nxt_st = st_ff;
    ack = 1'b0;
    load_tx = 1'b0;
    pop = 1'b0;
    nxt_st.scl_sync = {st_ff.scl_sync[1:0], i_scl};
    nxt_st.sda_sync = {st_ff.sda_sync[1:0], i_sda};
    if (st_ff.scl_sync[1] == st_ff.scl_sync[2])
    begin
      nxt_st.scl_q = st_ff.scl_sync[2];
    end
    if (st_ff.sda_sync[1] == st_ff.sda_sync[2])
    begin
      nxt_st.sda_q = st_ff.sda_sync[2];
    end
    rise = nxt_st.scl_q & ~st_ff.scl_q;
    fall = ~nxt_st.scl_q & st_ff.scl_q;
    start = st_ff.scl_q & nxt_st.scl_q & st_ff.sda_q & ~nxt_st.sda_q;
    stop = st_ff.scl_q & nxt_st.scl_q & ~st_ff.sda_q & nxt_st.sda_q;
    nxt_st.wr_valid = 1'b0;
    nxt_st.lock_commit = 1'b0;
    nxt_st.locked = st_ff.locked | i_locked_nv;
    if (st_ff.req_valid && i_req_ready)
    begin
      nxt_st.req_valid = 1'b0;
    end
    push = i_rd_valid && st_ff.rd_ready;

    // ========================================================
    // Bus sequencing
    if (start)
    begin
      nxt_st.ph = ST_RX;
      nxt_st.kind = K_DEV;
      nxt_st.cnt = 4'h0;
      nxt_st.sda_oe = 1'b0;
      nxt_st.lock_op = 1'b0;
      nxt_st.lock_pend = 1'b0;
    end
    else if (stop)
    begin
      nxt_st.ph = ST_IDLE;
      nxt_st.sda_oe = 1'b0;
      if (st_ff.lock_pend)
      begin
        nxt_st.busy = 1'b1;
        nxt_st.busy_cnt = 32'(LOCK_CYCLES);
        nxt_st.lock_pend = 1'b0;
      end
    end
    else
    begin
      case (st_ff.ph)
        ST_RX:
          if (rise && st_ff.cnt < `BYTE_BITS)
          begin
            nxt_st.sh = {st_ff.sh[6:0], st_ff.sda_q};
            nxt_st.cnt = st_ff.cnt + 4'h1;
          end
          else if (fall && st_ff.cnt == `BYTE_BITS)
          begin
            case (st_ff.kind)
              K_DEV:
              begin
                ack = !st_ff.busy && dev_match(st_ff.sh);
                nxt_st.dev = st_ff.sh;
                if (ack && st_ff.sh[0] == `DEV_DIR_READ)
                begin
                  nxt_st.sec = (st_ff.sh[7:4] == `DEV_TYPE_SEC);
                  nxt_st.req_valid = 1'b1;
                  nxt_st.req_addr = st_ff.ptr;
                  nxt_st.req_sec = (st_ff.sh[7:4] == `DEV_TYPE_SEC);
                end
              end
              K_WA:
                if (st_ff.dev[7:4] == `DEV_TYPE_SEC)
                begin
                  if (st_ff.sh[7:4] == `LOCK_CMD_CODE)
                  begin
                    ack = !st_ff.locked;
                    nxt_st.lock_op = 1'b1;
                  end
                  else if (st_ff.sh[7:6] == `SEC_SEL_CODE)
                  begin
                    ack = 1'b1;
                    nxt_st.ptr[7:0] = st_ff.sh;
                    nxt_st.sec = 1'b1;
                  end
                end
                else
                begin
                  ack = 1'b1;
                  nxt_st.ptr = {st_ff.dev[HB:1], st_ff.sh};
                  nxt_st.sec = 1'b0;
                end
              default:
                if (st_ff.lock_op)
                begin
                  ack = !st_ff.locked;
                  nxt_st.lock_pend = ack;
                end
                else
                begin
                  // Serial half ignores writes; user half is two pages
                  ack = !(st_ff.sec && st_ff.locked);
                  nxt_st.wr_valid = ack &&
                    (!st_ff.sec || st_ff.ptr[`SEC_USER_BIT]);
                  nxt_st.wr_addr = st_ff.ptr;
                  nxt_st.wr_sec = st_ff.sec;
                  nxt_st.wr_data = st_ff.sh;
                  if (ack)
                  begin
                    nxt_st.ptr = inc_ptr(st_ff.ptr, st_ff.sec);
                  end
                end
            endcase
            nxt_st.sda_oe = ack;
            nxt_st.ph = ack ? ST_RX_ACK : ST_IDLE;
          end
        ST_RX_ACK:
          if (fall)
          begin
            nxt_st.sda_oe = 1'b0;
            nxt_st.cnt = 4'h0;
            if (st_ff.kind == K_DEV && st_ff.dev[0] == `DEV_DIR_READ)
            begin
              load_tx = 1'b1;
            end
            else
            begin
              nxt_st.ph = ST_RX;
              nxt_st.kind = (st_ff.kind == K_DEV) ? K_WA : K_WD;
            end
          end
        ST_TX:
          if (fall)
          begin
            if (st_ff.cnt == `BYTE_BITS)
            begin
              nxt_st.sda_oe = 1'b0;
              nxt_st.ph = ST_TX_ACK;
            end
            else
            begin
              nxt_st.sda_oe = ~st_ff.sh[6];
              nxt_st.sh = {st_ff.sh[6:0], 1'b0};
              nxt_st.cnt = st_ff.cnt + 4'h1;
            end
          end
        ST_TX_ACK:
          if (rise)
          begin
            if (!st_ff.sda_q)
            begin
              nxt_st.ph = ST_TX_LOAD;
              nxt_st.req_valid = 1'b1;
              nxt_st.req_addr = st_ff.ptr;
              nxt_st.req_sec = st_ff.sec;
            end
            else
            begin
              nxt_st.ph = ST_IDLE;
            end
          end
        ST_TX_LOAD:
          load_tx = fall;
        default:
          nxt_st.ph = ST_IDLE;
      endcase
    end

    // First data bit goes out on the same low phase
    if (load_tx)
    begin
      pop = (st_ff.count != '0);
      nxt_st.sh = pop ? st_ff.mem[st_ff.rp] : `IDLE_BYTE;
      nxt_st.sda_oe = pop ? ~st_ff.mem[st_ff.rp][7] : 1'b0;
      nxt_st.cnt = 4'h1;
      nxt_st.ph = ST_TX;
      nxt_st.ptr = inc_ptr(st_ff.ptr, st_ff.sec);
    end

    // ========================================================
    // Read data buffer; a late word is dropped at the next start or stop
    if (push)
    begin
      nxt_st.mem[st_ff.wp] = i_rd_data;
      nxt_st.wp = PW'((32'(st_ff.wp) + 1) % DEPTH);
    end
    if (pop)
    begin
      nxt_st.rp = PW'((32'(st_ff.rp) + 1) % DEPTH);
    end
    nxt_st.count = CW'(st_ff.count + CW'(push) - CW'(pop));
    if (start || stop)
    begin
      nxt_st.rp = nxt_st.wp;
      nxt_st.count = '0;
    end
    nxt_st.rd_ready = (nxt_st.count != CW'(DEPTH));

    // ========================================================
    // Self-timed lock cycle; the bus is refused while it runs
    if (st_ff.busy)
    begin
      if (st_ff.busy_cnt <= 32'h1)
      begin
        nxt_st.busy = 1'b0;
        nxt_st.locked = 1'b1;
        nxt_st.lock_commit = 1'b1;
      end
      else
      begin
        nxt_st.busy_cnt = st_ff.busy_cnt - 32'h1;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      st_ff <= RST;
    else
      st_ff <= nxt_st;
  end

  assign o_sda_o = st_ff.sda_o;
  assign o_sda_oe = st_ff.sda_oe;
  assign o_req_valid = st_ff.req_valid;
  assign o_req_addr = st_ff.req_addr;
  assign o_req_sec = st_ff.req_sec;
  assign o_rd_ready = st_ff.rd_ready;
  assign o_wr_valid = st_ff.wr_valid;
  assign o_wr_addr = st_ff.wr_addr;
  assign o_wr_sec = st_ff.wr_sec;
  assign o_wr_data = st_ff.wr_data;
  assign o_lock_commit = st_ff.lock_commit;
  assign o_locked = st_ff.locked;
  assign o_busy = st_ff.busy;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_host_ack;
    st_ff.ph == ST_TX_ACK && rise && !st_ff.sda_q && !start && !stop;
  endsequence

  sequence s_host_nack;
    st_ff.ph == ST_TX_ACK && rise && st_ff.sda_q && !start && !stop;
  endsequence

  sequence s_load;
    load_tx && !start && !stop;
  endsequence

  a_ptr_advance: assert property (
    s_load |=> st_ff.ptr == inc_ptr($past(st_ff.ptr), $past(st_ff.sec)))
    else $error("pointer did not advance after a byte was sent");

  a_array_wrap: assert property (
    s_load ##0 (!st_ff.sec && &st_ff.ptr) |=> st_ff.ptr == '0)
    else $error("array pointer did not wrap to zero");

  a_sec_wrap: assert property (
    s_load ##0 (st_ff.sec && &st_ff.ptr[4:0]) |=> st_ff.ptr[4:0] == 5'h0)
    else $error("security pointer did not wrap to byte zero");

  a_nack_ends: assert property (
    s_host_nack |=> st_ff.ph == ST_IDLE && !st_ff.sda_oe [*2])
    else $error("read continued after host no-acknowledge");

  a_ack_fetch: assert property (
    s_host_ack |=> st_ff.req_valid && st_ff.req_addr == $past(st_ff.ptr))
    else $error("no fetch of next byte after host acknowledge");

  a_read_ack: assert property (
    st_ff.ph == ST_RX && st_ff.kind == K_DEV && fall &&
    st_ff.cnt == `BYTE_BITS && dev_match(st_ff.sh) && !st_ff.busy &&
    st_ff.sh[0] && !start && !stop
    |=> st_ff.sda_oe && st_ff.req_valid ##1 st_ff.ph == ST_RX_ACK)
    else $error("read address not acknowledged");

  a_lock_refused: assert property (
    st_ff.ph == ST_RX && st_ff.kind == K_WA && st_ff.locked && fall &&
    st_ff.cnt == `BYTE_BITS && st_ff.dev[7:4] == `DEV_TYPE_SEC &&
    st_ff.sh[7:4] == `LOCK_CMD_CODE && !start && !stop
    |=> !st_ff.sda_oe && st_ff.ph == ST_IDLE)
    else $error("lock command acknowledged while locked");

  a_locked_nowrite: assert property (
    st_ff.locked |-> ##1 !(st_ff.wr_valid && st_ff.wr_sec))
    else $error("security write issued while locked");

  a_serial_ro: assert property (
    st_ff.wr_valid && st_ff.wr_sec |-> st_ff.wr_addr[`SEC_USER_BIT])
    else $error("write issued to serial number half");

  a_lock_commit: assert property (
    stop && st_ff.lock_pend |=> st_ff.busy ##1 st_ff.busy)
    else $error("stop did not start the lock cycle");

  a_lock_done: assert property (
    st_ff.busy && st_ff.busy_cnt == 32'h1 |=> st_ff.locked && !st_ff.busy)
    else $error("lock cycle end did not lock the region");

  a_buf_full: assert property (
    st_ff.count == CW'(DEPTH) |-> !o_rd_ready)
    else $error("buffer ready while full");

endmodule

//--- dv/twi_host_model.sv
/*
  Behavioural two-wire bus host: start, stop and byte transfers.
  Assumes the testbench resolves the open-drain data line.
*/
module twi_host_model (
  // Clock
  input wire logic i_clk,
  // Resolved data line
  input wire logic i_sda_line,
  // Bus pins driven by the host
  output logic o_scl,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Low phase split 2+6 so data never moves with the clock edge
  task automatic bit_io(input logic v, output logic s);
    o_sda = v;
    hold(6);
    o_scl = 1'b1;
    hold(8);
    s = i_sda_line;
    o_scl = 1'b0;
    hold(2);
  endtask

  // Serves as first start and as repeated start
  task automatic start();
    o_sda = 1'b1;
    hold(6);
    o_scl = 1'b1;
    hold(8);
    o_sda = 1'b0;
    hold(8);
    o_scl = 1'b0;
    hold(2);
  endtask

  task automatic stop();
    o_sda = 1'b0;
    hold(6);
    o_scl = 1'b1;
    hold(8);
    o_sda = 1'b1;
    hold(8);
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(last, s);
  endtask
endmodule

//--- dv/testbench.sv
/*
  Self-checking bench of the two-wire EEPROM read logic.
  Assumes the host model beside it; memory and lock store live here.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int AW = 9;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic scl, host_sda, sda_line, o_sda_o, o_sda_oe;
  logic o_req_valid, o_req_sec, o_rd_ready, o_wr_valid, o_wr_sec;
  logic o_lock_commit, o_locked, o_busy;
  logic i_req_ready = 1'b0;
  logic i_rd_valid = 1'b0;
  logic i_locked_nv = 1'b0;
  logic [7:0] i_rd_data = 8'h00;
  logic [AW-1:0] o_req_addr, o_wr_addr;
  logic [7:0] o_wr_data, pdata;
  logic [7:0] mem [512];
  logic [7:0] sec [32];
  logic [7:0] x_mem [512];
  logic [7:0] x_sec [32];
  logic pend = 1'b0;
  logic waited = 1'b0;
  int ptr, n_mismatch, samples_checked;

  always #2.5 i_clk = ~i_clk;
  assign sda_line = host_sda & (~o_sda_oe | o_sda_o);

  eeprom_rd #(.ADDR_W(AW), .LOCK_CYCLES(200)) u_eeprom_rd (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda_line),
    .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_req_valid(o_req_valid),
    .i_req_ready(i_req_ready), .o_req_addr(o_req_addr),
    .o_req_sec(o_req_sec), .i_rd_valid(i_rd_valid),
    .i_rd_data(i_rd_data), .o_rd_ready(o_rd_ready),
    .o_wr_valid(o_wr_valid), .o_wr_addr(o_wr_addr), .o_wr_sec(o_wr_sec),
    .o_wr_data(o_wr_data), .i_locked_nv(i_locked_nv),
    .o_lock_commit(o_lock_commit), .o_locked(o_locked), .o_busy(o_busy));

  twi_host_model u_twi_host_model (.i_clk(i_clk), .i_sda_line(sda_line),
    .o_scl(scl), .o_sda(host_sda));

  // ==========================================================
  // Memory and lock store: at most one stall so data beats the clock
  always @(posedge i_clk)
  begin
    #1;
    i_req_ready = 1'b0;
    i_rd_valid = 1'b0;
    if (o_lock_commit)
      i_locked_nv = 1'b1;
    if (o_wr_valid && o_wr_sec)
      sec[o_wr_addr[4:0]] = o_wr_data;
    else if (o_wr_valid)
      mem[o_wr_addr] = o_wr_data;
    if (pend)
    begin
      i_rd_valid = 1'b1;
      i_rd_data = pdata;
      pend = 1'b0;
    end
    else if (o_req_valid && (waited || $urandom_range(1, 0) == 1))
    begin
      i_req_ready = 1'b1;
      pdata = o_req_sec ? sec[o_req_addr[4:0]] : mem[o_req_addr];
      pend = 1'b1;
      waited = 1'b0;
    end
    else if (o_req_valid)
      waited = 1'b1;
  end

  // ==========================================================
  // Checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic report_and_stop();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Reference pointer: array wraps at its top, security within 32
  function automatic int nxt(input int p, input logic s);
    return s ? (p & 32'h1e0) | ((p + 1) & 32'h1f) : (p + 1) % 512;
  endfunction

  task automatic send_dev(input logic [7:0] dev, input logic want);
    logic a;
    u_twi_host_model.start();
    u_twi_host_model.put_byte(dev, a);
    check(a, want);
  endtask

  task automatic load(input logic [7:0] dev, input logic [7:0] wa,
    input logic want);
    logic a;
    send_dev(dev, 1'b1);
    u_twi_host_model.put_byte(wa, a);
    check(a, want);
    // A refused or lock word address leaves the pointer alone
    if (want && !(dev[4] && wa[7:4] == 4'h6))
      ptr = dev[4] ? (ptr & 32'h100) | wa : {dev[1], wa};
  endtask

  task automatic read_n(input logic [7:0] dev, input int n);
    logic [7:0] b;
    send_dev(dev | 8'h01, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      u_twi_host_model.get_byte(i == n - 1, b);
      check(b, dev[4] ? x_sec[ptr & 31] : x_mem[ptr]);
      ptr = nxt(ptr, dev[4]);
    end
    u_twi_host_model.stop();
  endtask

  task automatic write_b(input logic [7:0] dev, input logic [7:0] wa,
    input logic [7:0] d, input logic want);
    logic a;
    load(dev, wa, 1'b1);
    u_twi_host_model.put_byte(d, a);
    check(a, want);
    u_twi_host_model.stop();
    if (!dev[4])
      x_mem[ptr] = d;
    else if (want && wa[4])
      x_sec[wa[4:0]] = d;
    // An accepted data byte other than the lock's moves the pointer, serial half included
    if (want && !(dev[4] && wa[7:4] == 4'h6))
      ptr = nxt(ptr, dev[4]);
  endtask

  initial
  begin
    repeat (60000) @(posedge i_clk);
    n_mismatch++;
    report_and_stop();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [8:0] r;
    logic [7:0] dv;
    void'($urandom(32'h5ec8cd57));
    for (int i = 0; i < 512; i++)
    begin
      mem[i] = 8'($urandom);
      x_mem[i] = mem[i];
    end
    for (int i = 0; i < 32; i++)
    begin
      sec[i] = 8'($urandom);
      x_sec[i] = sec[i];
    end
    repeat (3) @(posedge i_clk);
    #1;
    i_rst_n = 1'b1;
    repeat (8) @(posedge i_clk);
    #1;
    check(o_locked, 1'b0);
    load(8'ha2, 8'hfe, 1'b1);
    read_n(8'ha2, 4);
    read_n(8'ha0, 2);
    send_dev(8'he0, 1'b0);
    u_twi_host_model.stop();
    read_n(8'ha0, 1);
    write_b(8'ha0, 8'h10, 8'h5a, 1'b1);
    read_n(8'ha0, 1);
    load(8'ha0, 8'h10, 1'b1);
    read_n(8'ha0, 1);
    load(8'hb0, 8'h9e, 1'b1);
    read_n(8'hb0, 4);
    read_n(8'hb0, 1);
    load(8'hb0, 8'h40, 1'b0);
    u_twi_host_model.stop();
    write_b(8'hb0, 8'h83, 8'ha5, 1'b1);
    write_b(8'hb0, 8'h94, 8'h3c, 1'b1);
    read_n(8'hb0, 1);
    load(8'hb0, 8'h83, 1'b1);
    read_n(8'hb0, 18);
    for (int i = 0; i < 6; i++)
    begin
      r = 9'($urandom);
      dv = {4'ha, 2'h0, r[8], 1'b0};
      write_b(dv, r[7:0], 8'($urandom), 1'b1);
      read_n(dv, 1);
      load(dv, r[7:0], 1'b1);
      read_n(dv, 2);
      load(8'hb0, {3'h4, r[4:0]}, 1'b1);
      read_n(8'hb0, 3);
    end
    write_b(8'hb0, 8'h60, 8'h00, 1'b1);
    check(o_busy, 1'b1);
    send_dev(8'ha0, 1'b0);
    u_twi_host_model.stop();
    for (int i = 0; i < 400 && o_locked !== 1'b1; i++)
      @(posedge i_clk);
    #1;
    check(o_locked, 1'b1);
    load(8'hb0, 8'h60, 1'b0);
    u_twi_host_model.stop();
    write_b(8'hb0, 8'h94, 8'hc3, 1'b0);
    load(8'hb0, 8'h94, 1'b1);
    read_n(8'hb0, 1);
    report_and_stop();
  end
endmodule
